/* src/pswk_consts.svh */
// register offsets, field positions and codes for the port 3 wake compare block
`ifndef PSWK_CONSTS_SVH
`define PSWK_CONSTS_SVH
`define PSWK_ADDR_STATUS    12'hf0a
`define PSWK_ADDR_SELECT    12'hf0e
`define PSWK_SRC_NONE       2'h0
`define PSWK_SRC_READ       2'h1
`define PSWK_SRC_WRITE      2'h2
`define PSWK_P3_SRC_LO      2
`define PSWK_IRQ_EN_BIT     4
`define PSWK_P3M_IRQ_BIT    1
`define PSWK_SEL_RESET      4'h0
`define PSWK_REF_RESET      4'h0
`define PSWK_UNDEF_READ     3'h0
`define PSWK_SEL_LO         0
`define PSWK_SEL_HI         3
`define PSWK_P2_SRC_LO      0
`define PSWK_P2_SRC_HI      1
`define PSWK_SRC_RSVD       2'h3
`define PSWK_IRQ_RESET      1'b0
`define PSWK_BIT_RESET      1'b0
`define PSWK_PIN_RESET      4'h0
`define PSWK_RDATA_IDLE     8'h00
`endif

/* src/pswk_pkg.sv */
// types for the port 3 wake compare block
package pswk_pkg;
  typedef enum logic [1:0] {
    PSWK_SRC_NONE_E  = 2'b00,
    PSWK_SRC_READ_E  = 2'b01,
    PSWK_SRC_WRITE_E = 2'b10
  } pswk_src_e;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } pswk_bus_s;
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [3:0] val;
  } pswk_port_acc_s;
endpackage : pswk_pkg

/* src/pswk_pin_cmp.sv */
// per-pin wake comparator: select, reference and mismatch
`include "pswk_consts.svh"
module pswk_pin_cmp
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic sel,
  input  wire logic pin_sync,
  input  wire logic ref_load,
  input  wire logic ref_val,
  input  wire logic use_ref,
  output logic      wake
);
  logic ref_r;
  logic ref_nxt;
  always_comb
  begin
    ref_nxt = ref_r;
    if (ref_load)
    begin
      ref_nxt = ref_val;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      ref_r <= `PSWK_BIT_RESET;
    end
    else
    begin
      ref_r <= ref_nxt;
    end
  end
  assign wake = sel & (use_ref ? (pin_sync != ref_r) : ~pin_sync);
endmodule // pswk_pin_cmp

/* src/pswk_wake.sv */
// port 3 stop-mode wake compare logic with its two registers
`include "pswk_consts.svh"
// Function
// - Each of the four low select bits enables the matching port 3 pin as a wake source.
// - Any number of pins may be selected and each compares with its own reference.
// - With no reference access recorded, a selected pin wakes on a low level.
// - Every later read or write of the port 3 data register latches a new reference.
// - A read that supplied the reference shows code 01 in status bits 3:2.
// - A write that supplied the reference shows code 10, and code 11 is never produced.
// - Software writing 00 to the port 3 field restores the low-level default comparison.
// - Status bits 1:0 report the port 2 reference source with the same coding.
// - Bit 4 routes wake events to interrupt line one; clear with mode bit 1 clear gives none.
// - Neither register is cleared by a stop-mode recovery.
// - An event from any selected source triggers stop-mode recovery.
module pswk_wake #(
  parameter int NPINS = 4
)
(
  input  wire logic                    mclk,
  input  wire logic                    sys_rst,
  input  wire pswk_pkg::pswk_bus_s     bus,
  output logic [7:0]                   rdata,
  input  wire pswk_pkg::pswk_port_acc_s p3_acc,
  input  wire logic [1:0]              p2_src,
  input  wire logic                    p2_src_load,
  input  wire logic [3:0]              port3_pin,
  input  wire logic                    port3_mode_irq,
  input  wire logic                    other_wake,
  output logic                         stop_recovery_event,
  output logic                         interrupt_request_line_one
);
  // elaboration check: fields and comparators are sized for four pins
  if (NPINS != 4)
  begin : g_npins_check
    $error("pswk_wake supports four pins only");
  end

  logic [3:0] sel_r;
  logic [3:0] sel_nxt;
  logic [1:0] p3_src_r;
  logic [1:0] p3_src_nxt;
  logic [1:0] p2_src_r;
  logic [1:0] p2_src_nxt;
  logic       irq_en_r;
  logic       irq_en_nxt;
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic [3:0] wake_vec;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       wr_stat;
  logic       wr_sel;
  logic       use_ref;

  assign wr_stat = bus.wr && (bus.addr == `PSWK_ADDR_STATUS);
  assign wr_sel  = bus.wr && (bus.addr == `PSWK_ADDR_SELECT);

  always_comb
  begin
    sel_nxt    = sel_r;
    p3_src_nxt = p3_src_r;
    p2_src_nxt = p2_src_r;
    irq_en_nxt = irq_en_r;
    // select register write, upper bits ignored
    if (wr_sel)
    begin
      sel_nxt = bus.wdata[`PSWK_SEL_HI:`PSWK_SEL_LO];
    end
    // software may clear the source field
    if (wr_stat)
    begin
      p3_src_nxt = (bus.wdata[`PSWK_P3_SRC_LO+1:`PSWK_P3_SRC_LO] == `PSWK_SRC_NONE) ?
                   `PSWK_SRC_NONE : p3_src_r;
      p2_src_nxt = (bus.wdata[`PSWK_P2_SRC_HI:`PSWK_P2_SRC_LO] == `PSWK_SRC_NONE) ?
                   `PSWK_SRC_NONE : p2_src_r;
      irq_en_nxt = bus.wdata[`PSWK_IRQ_EN_BIT];
    end
    if (p3_acc.wr)
    begin
      p3_src_nxt = `PSWK_SRC_WRITE;
    end
    else if (p3_acc.rd)
    begin
      p3_src_nxt = `PSWK_SRC_READ;
    end
    if (p2_src_load && (p2_src != `PSWK_SRC_RSVD))
    begin
      p2_src_nxt = p2_src;
    end
  end

  // full reset clears; nothing else does
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      sel_r    <= `PSWK_SEL_RESET;
      p3_src_r <= `PSWK_SRC_NONE;
      p2_src_r <= `PSWK_SRC_NONE;
      irq_en_r <= `PSWK_IRQ_RESET;
    end
    else
    begin
      sel_r    <= sel_nxt;
      p3_src_r <= p3_src_nxt;
      p2_src_r <= p2_src_nxt;
      irq_en_r <= irq_en_nxt;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      pin_meta_r <= `PSWK_PIN_RESET;
      pin_sync_r <= `PSWK_PIN_RESET;
    end
    else
    begin
      pin_meta_r <= port3_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign use_ref = (p3_src_r != `PSWK_SRC_NONE);

  genvar g;
  generate
    for (g = 0; g < NPINS; g++)
    begin : g_pin
      pswk_pin_cmp u_cmp (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .sel      (sel_r[g]),
        .pin_sync (pin_sync_r[g]),
        .ref_load (p3_acc.rd | p3_acc.wr),
        .ref_val  (p3_acc.val[g]),
        .use_ref  (use_ref),
        .wake     (wake_vec[g])
      );
    end
  endgenerate

  assign stop_recovery_event = (|wake_vec) | other_wake;
  assign interrupt_request_line_one = stop_recovery_event & (irq_en_r | port3_mode_irq);

  always_comb
  begin
    rdata_nxt = `PSWK_RDATA_IDLE;
    if (bus.rd && (bus.addr == `PSWK_ADDR_STATUS))
    begin
      rdata_nxt = {`PSWK_UNDEF_READ, irq_en_r, p3_src_r, p2_src_r};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      rdata_r <= `PSWK_RDATA_IDLE;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  // assertions
  a_sel_enables: assert property (@(posedge mclk) disable iff (sys_rst)
    !sel_r[0] |-> !wake_vec[0])
    else $error("unselected pin woke");
  a_sel_write: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_sel |=> sel_r == $past(bus.wdata[`PSWK_SEL_HI:`PSWK_SEL_LO]))
    else $error("select write lost");
  a_default_zero: assert property (@(posedge mclk) disable iff (sys_rst)
    (sel_r[1] && !use_ref && !pin_sync_r[1]) |-> stop_recovery_event)
    else $error("default low compare missed");
  a_ref_latch: assert property (@(posedge mclk) disable iff (sys_rst)
    (p3_acc.wr && !wr_sel) ##1 (sel_r[2] && pin_sync_r[2] != $past(p3_acc.val[2])) |-> wake_vec[2])
    else $error("reference mismatch missed");
  a_read_code: assert property (@(posedge mclk) disable iff (sys_rst)
    (p3_acc.rd && !p3_acc.wr) |=> p3_src_r == `PSWK_SRC_READ)
    else $error("read code wrong");
  a_write_code: assert property (@(posedge mclk) disable iff (sys_rst)
    p3_acc.wr |=> p3_src_r == `PSWK_SRC_WRITE)
    else $error("write code wrong");
  a_no_rsvd_code: assert property (@(posedge mclk) disable iff (sys_rst)
    (p3_src_r != `PSWK_SRC_RSVD) && (p2_src_r != `PSWK_SRC_RSVD))
    else $error("reserved code shown");
  a_clear_code: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_stat && bus.wdata[3:2] == 2'b00 && !p3_acc.rd && !p3_acc.wr) |=> !use_ref)
    else $error("clear ignored");
  a_p2_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    (wr_stat && bus.wdata[1:0] == `PSWK_SRC_NONE && !p2_src_load) |=> p2_src_r == `PSWK_SRC_NONE)
    else $error("port 2 clear ignored");
  a_p2_code: assert property (@(posedge mclk) disable iff (sys_rst)
    (p2_src_load && p2_src != `PSWK_SRC_RSVD) |=> p2_src_r == $past(p2_src))
    else $error("port 2 code lost");
  a_p2_rsvd: assert property (@(posedge mclk) disable iff (sys_rst)
    (p2_src_load && p2_src == `PSWK_SRC_RSVD && !wr_stat) |=> p2_src_r == $past(p2_src_r))
    else $error("port 2 reserved code taken");
  a_irq_gate: assert property (@(posedge mclk) disable iff (sys_rst)
    (!irq_en_r && !port3_mode_irq) |-> !interrupt_request_line_one)
    else $error("irq leaked");
  a_irq_route: assert property (@(posedge mclk) disable iff (sys_rst)
    (irq_en_r && stop_recovery_event) |-> interrupt_request_line_one)
    else $error("irq not routed");
  a_irq_en_write: assert property (@(posedge mclk) disable iff (sys_rst)
    wr_stat |=> irq_en_r == $past(bus.wdata[`PSWK_IRQ_EN_BIT]))
    else $error("irq enable write lost");
  a_regs_persist: assert property (@(posedge mclk) disable iff (sys_rst)
    (!wr_sel && !wr_stat) |=> (sel_r == $past(sel_r) && irq_en_r == $past(irq_en_r)))
    else $error("register changed without write");
  a_any_source: assert property (@(posedge mclk) disable iff (sys_rst)
    other_wake |-> stop_recovery_event)
    else $error("source lost");
  a_wake_release: assert property (@(posedge mclk) disable iff (sys_rst)
    (|wake_vec) |-> stop_recovery_event)
    else $error("pin wake lost");
  a_reset_clear: assert property (@(posedge mclk)
    sys_rst |=> (sel_r == 4'h0 && !irq_en_r && p3_src_r == 2'b00))
    else $error("reset value");
endmodule // pswk_wake

/* dv/pswk_pin_src.sv */
// model of the external sources driving the four port 3 pins
module pswk_pin_src
(
  input  wire logic       mclk,
  input  wire logic [3:0] want,
  output logic [3:0]      port3_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins change on a clock edge, the worst case for the synchroniser
  initial
  begin
    port3_pin = 4'h0;
    forever @(posedge mclk) port3_pin <= want;
  end
endmodule // pswk_pin_src

/* dv/tb.sv */
// self-checking bench for the port 3 wake compare block
`include "pswk_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     mclk, sys_rst, p2_src_load, port3_mode_irq, other_wake, irq_en, clr;
  pswk_pkg::pswk_bus_s      bus;
  pswk_pkg::pswk_port_acc_s p3_acc;
  logic [1:0]               p2_src, src3, src2;
  logic [3:0]               want, port3_pin, sel, refv;
  logic [7:0]               rdata, d;
  logic                     stop_recovery_event, interrupt_request_line_one;
  int                       miscompares, checked;
  pswk_wake dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata), .p3_acc(p3_acc),
    .p2_src(p2_src), .p2_src_load(p2_src_load), .port3_pin(port3_pin), .port3_mode_irq(port3_mode_irq),
    .other_wake(other_wake), .stop_recovery_event(stop_recovery_event),
    .interrupt_request_line_one(interrupt_request_line_one));
  pswk_pin_src pins (.mclk(mclk), .want(want), .port3_pin(port3_pin));
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_lvl(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e)
    begin
      miscompares++;
      $display("unexpected %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(negedge mclk) bus <= '{1'b1, 1'b0, a, v};
    @(negedge mclk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(negedge mclk) bus <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk) v = rdata;
    bus.rd <= 1'b0;
  endtask
  task automatic acc(input logic w, input logic [3:0] v);
    @(negedge mclk) p3_acc <= '{~w, w, v};
    @(negedge mclk) p3_acc <= '0;
    refv = v;
    src3 = w ? 2'h2 : 2'h1;
  endtask
  // port 2 block reports its source; the reserved code leaves it unchanged
  task automatic p2_report(input logic [1:0] c);
    @(negedge mclk) p2_src <= c;
    p2_src_load <= 1'b1;
    @(negedge mclk) p2_src_load <= 1'b0;
    if (c != 2'h3)
      src2 = c;
  endtask
  // default comparison wakes on a low pin
  function automatic logic exp_wake();
    return |(sel & (src3 == 2'h0 ? ~want : want ^ refv)) | other_wake;
  endfunction
  task automatic check_all;
    logic [7:0] r;
    repeat (4) @(negedge mclk);
    chk_lvl("event", exp_wake(), stop_recovery_event);
    chk_lvl("irq", exp_wake() & (irq_en | port3_mode_irq), interrupt_request_line_one);
    rd(`PSWK_ADDR_STATUS, r);
    chk("status", {3'h0, irq_en, src3, src2}, r);
  endtask
  initial
  begin
    #50000;
    miscompares++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(44388));
    {bus, p3_acc, p2_src, p2_src_load, port3_mode_irq, other_wake} = '0;
    sys_rst = 1'b1;
    {want, sel, refv, src3, src2, irq_en, miscompares, checked} = '0;
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    check_all();
    rd(`PSWK_ADDR_SELECT, d);
    chk("select", 8'h00, d);
    rd(12'hf0b, d);
    chk("unmapped", 8'h00, d);
    sel = 4'h1;
    wr(`PSWK_ADDR_SELECT, 8'hf1);
    check_all();
    // written zero reference, then a high pin wakes
    acc(1'b1, 4'h0);
    check_all();
    want = 4'h1;
    check_all();
    // status clear and port read in one cycle: the access wins
    @(negedge mclk) bus <= '{1'b1, 1'b0, `PSWK_ADDR_STATUS, 8'h00};
    p3_acc <= '{1'b1, 1'b0, 4'h1};
    @(negedge mclk) bus.wr <= 1'b0;
    p3_acc <= '0;
    {src3, refv} = {2'h1, 4'h1};
    check_all();
    // read and write in one cycle: the write wins
    @(negedge mclk) p3_acc <= '{1'b1, 1'b1, 4'h0};
    @(negedge mclk) p3_acc <= '0;
    {src3, refv} = {2'h2, 4'h0};
    check_all();
    // the reserved port 2 code is ignored
    p2_report(2'h2);
    p2_report(2'h3);
    check_all();
    for (int i = 0; i < 60; i++)
    begin
      sel = 4'($urandom);
      wr(`PSWK_ADDR_SELECT, {4'hf, sel});
      irq_en = 1'($urandom);
      clr = 1'($urandom);
      wr(`PSWK_ADDR_STATUS, {3'h0, irq_en, clr ? 4'h0 : 4'hf});
      if (clr)
        {src3, src2} = 4'h0;
      else
        acc(1'($urandom), 4'($urandom));
      if ($urandom % 2)
        p2_report(2'($urandom % 3 + 1));
      want = 4'($urandom);
      port3_mode_irq = 1'($urandom);
      other_wake = ($urandom % 8 == 0);
      check_all();
    end
    tally_and_finish();
  end
endmodule // tb
